// ### hdl/fast_function_range_and_cal_guard.sv
// shortcut function and range decoder with calibration guard and error reporting
`timescale 1ns/1ps
// Notes on behaviour
// - function codes one to four pick voltage, current, two-wire and four-wire ohms
// - shortcuts never select alternating, frequency or period functions
// - voltage ranges 0.1 V to 300 V, current ranges 0.01 A to 3 A
// - ohms range codes one to seven span 100 ohm to 100 megohm by decades
// - a range command changes only the selected function's range
// - reselecting a function brings back the range it last held
// - shortcuts update configuration exactly like the standard sense command
// - security code up to twelve alphanumerics, first a letter
// - code longer than twelve characters is rejected with error 704
// - secure and unsecure need the same code, mismatch gives error 703
// - calibration request while secured is refused with error 702
// - security disabled by jumper reports error 701 after power-on
// - device clear during calibration aborts it with error 705
// - invalid calibration value gives 706, mismatched signal gives 707
// - no calibration for ac current, period, continuity, diode, ratio, 100 megohm: 709
// - each stored calibration area has its own checksum error, 740 to 748
// - each self-test failure reports its own error, 602 to 626, except 608 and 624, which are dropped
module fast_function_range_and_cal_guard (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // shortcut commands
  input wire logic cmd_valid,
  input wire meter_pkg::op_t cmd_op,
  input wire logic [3:0] cmd_arg,
  // security code stream
  input wire logic code_valid,
  input wire logic [7:0] code_char,
  input wire logic code_last,
  input wire logic code_unsecure,
  // calibration
  input wire logic cal_req,
  input wire meter_pkg::cal_target_t cal_target,
  input wire logic cal_value_bad,
  input wire logic cal_signal_bad,
  input wire logic cal_done,
  input wire logic dev_clear,
  // self-test and checksum reports
  input wire logic st_fail_valid,
  input wire logic [4:0] st_fail_num,
  input wire logic cks_fail_valid,
  input wire logic [3:0] cks_area,
  // security jumper pin
  input wire logic sec_jumper_off,
  // configuration
  output meter_pkg::func_t cur_func,
  output logic [2:0] cur_range,
  output logic [11:0] range_all,
  output logic config_update,
  // guard state
  output logic secured,
  output logic cal_busy,
  // error report
  output logic err_valid,
  output logic signed [10:0] err_code
);
  import meter_pkg::*;

  sec_code_if sc ();

  sec_code_check u_check (
    .clock(clock),
    .nrst(nrst),
    .sc(sc.judge)
  );

  func_t func_r, func_nxt;
  logic [2:0] range_r [4];
  logic [2:0] range_nxt [4];
  logic update_r, update_nxt;
  logic cmd_err;
  logic jump_s1_r, jump_s2_r;
  logic jump_seen_r, jump_seen_nxt;
  logic jump_evt;
  logic secured_r, secured_nxt;
  logic unsec_req_r, unsec_req_nxt;
  cal_state_t cal_r, cal_nxt;
  logic cal_evt;
  logic signed [10:0] cal_code;
  logic code_evt;
  logic signed [10:0] code_code;
  logic st_evt;
  logic cks_evt;
  logic [SRC_COUNT-1:0] pend_r, pend_nxt, evt;
  logic signed [10:0] pcode_r [SRC_COUNT];
  logic signed [10:0] pcode_nxt [SRC_COUNT];
  logic signed [10:0] ecode [SRC_COUNT];
  logic err_valid_r, err_valid_nxt;
  logic signed [10:0] err_code_r, err_code_nxt;

  function automatic logic [2:0] max_range(input func_t f);
    unique case (f)
      DIRECT_VOLTAGE: max_range = MAX_RANGE_DCV;
      DIRECT_CURRENT: max_range = MAX_RANGE_DCI;
      TWO_WIRE_OHMS: max_range = MAX_RANGE_OHMS;
      FOUR_WIRE_OHMS: max_range = MAX_RANGE_OHMS;
    endcase
  endfunction : max_range

  function automatic logic st_known(input logic [4:0] n);
    st_known = (n >= ST_FIRST) && (n <= ST_LAST) && (n != ST_GAP_A) && (n != ST_GAP_B);
  endfunction : st_known

  // shortcut decode; each function keeps its own range so reselecting restores it
  always_comb begin
    func_nxt = func_r;
    range_nxt = range_r;
    update_nxt = 1'b0;
    cmd_err = 1'b0;
    if (cmd_valid) begin
      unique case (cmd_op)
        OP_FUNCTION: begin
          // only four codes exist; nothing reaches ac, frequency or period here
          if (cmd_arg >= FUNCTION_CODE_ONE && cmd_arg <= FUNCTION_CODE_FOUR) begin
            func_nxt = func_t'(2'(cmd_arg - FUNCTION_CODE_ONE));
            update_nxt = 1'b1;
          end else begin
            cmd_err = 1'b1;
          end
        end
        OP_RANGE: begin
          if (cmd_arg[3] == 1'b0 && cmd_arg[2:0] >= RANGE_CODE_ONE && cmd_arg[2:0] <= max_range(func_r)) begin
            range_nxt[func_r] = cmd_arg[2:0];
            update_nxt = 1'b1;
          end else begin
            cmd_err = 1'b1;
          end
        end
        OP_IGNORED_A, OP_IGNORED_B: begin
          cmd_err = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      func_r <= RESET_FUNC;
      range_r[DIRECT_VOLTAGE] <= RESET_RANGE_DCV;
      range_r[DIRECT_CURRENT] <= RESET_RANGE_DCI;
      range_r[TWO_WIRE_OHMS] <= RESET_RANGE_RES;
      range_r[FOUR_WIRE_OHMS] <= RESET_RANGE_FOUR_WIRE_OHMS;
      update_r <= 1'b0;
    end else begin
      func_r <= func_nxt;
      range_r <= range_nxt;
      update_r <= update_nxt;
    end
  end

  // jumper pin sync; first stage feeds only the second
  always_ff @(posedge clock) begin
    if (!nrst) begin
      jump_s1_r <= 1'b0;
      jump_s2_r <= 1'b0;
    end else begin
      jump_s1_r <= sec_jumper_off;
      jump_s2_r <= jump_s1_r;
    end
  end

  // one warning per reset, once the synced pin shows the jumper
  always_comb begin
    jump_evt = jump_s2_r && !jump_seen_r;
    jump_seen_nxt = jump_seen_r || jump_s2_r;
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      jump_seen_r <= 1'b0;
    end else begin
      jump_seen_r <= jump_seen_nxt;
    end
  end

  // code stream forwarded; the mode is held until the verdict returns
  assign sc.char_valid = code_valid;
  assign sc.char_data = code_char;
  assign sc.char_last = code_last;

  // secure state; a jumper overrides it rather than clearing it
  always_comb begin
    secured_nxt = secured_r;
    unsec_req_nxt = unsec_req_r;
    code_evt = 1'b0;
    code_code = ERR_NONE;
    if (code_valid) begin
      unsec_req_nxt = code_unsecure;
    end
    if (sc.done) begin
      if (sc.too_long) begin
        code_evt = 1'b1;
        code_code = ERR_CODE_LONG;
      end else if (sc.bad_form || !sc.match) begin
        code_evt = 1'b1;
        code_code = ERR_BAD_CODE;
      end else begin
        secured_nxt = !unsec_req_r;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      secured_r <= 1'b1;
      unsec_req_r <= 1'b0;
    end else begin
      secured_r <= secured_nxt;
      unsec_req_r <= unsec_req_nxt;
    end
  end

  // calibration sequencer; device clear outranks a same-cycle result
  always_comb begin
    cal_nxt = cal_r;
    cal_evt = 1'b0;
    cal_code = ERR_NONE;
    unique case (cal_r)
      CAL_IDLE: begin
        if (cal_req) begin
          cal_evt = 1'b1;
          if (secured_r && !jump_s2_r) begin
            cal_code = ERR_CAL_SECURED;
          end else if (cal_target == CAL_ACI || cal_target == CAL_PERIOD || cal_target == CAL_CONTINUITY ||
                       cal_target == CAL_DIODE || cal_target == CAL_RATIO ||
                       ((cal_target == CAL_RES) && range_r[TWO_WIRE_OHMS] == RANGE_100_MOHM) ||
                       ((cal_target == CAL_FOUR_WIRE_OHMS) && range_r[FOUR_WIRE_OHMS] == RANGE_100_MOHM)) begin
            cal_code = ERR_NO_CAL;
          end else begin
            cal_evt = 1'b0;
            cal_nxt = CAL_BUSY;
          end
        end
      end
      CAL_BUSY: begin
        if (dev_clear) begin
          cal_evt = 1'b1;
          cal_code = ERR_CAL_ABORT;
          cal_nxt = CAL_IDLE;
        end else if (cal_value_bad) begin
          cal_evt = 1'b1;
          cal_code = ERR_CAL_VALUE;
          cal_nxt = CAL_IDLE;
        end else if (cal_signal_bad) begin
          cal_evt = 1'b1;
          cal_code = ERR_CAL_SIGNAL;
          cal_nxt = CAL_IDLE;
        end else if (cal_done) begin
          cal_nxt = CAL_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      cal_r <= CAL_IDLE;
    end else begin
      cal_r <= cal_nxt;
    end
  end

  // error sources; unknown numbers and areas are dropped
  assign st_evt = st_fail_valid && st_known(st_fail_num);
  assign cks_evt = cks_fail_valid && (cks_area <= CKS_AREA_LAST);
  always_comb begin
    evt = '0;
    evt[SRC_JUMPER] = jump_evt;
    evt[SRC_CMD] = cmd_err;
    evt[SRC_CODE] = code_evt;
    evt[SRC_CAL] = cal_evt;
    evt[SRC_SELFTEST] = st_evt;
    evt[SRC_CKS] = cks_evt;
    ecode[SRC_JUMPER] = ERR_CAL_JUMPER;
    ecode[SRC_CMD] = ERR_OUT_OF_RANGE;
    ecode[SRC_CODE] = code_code;
    ecode[SRC_CAL] = cal_code;
    ecode[SRC_SELFTEST] = ERR_ST_BASE + 11'(st_fail_num);
    ecode[SRC_CKS] = ERR_CKS_BASE + 11'(cks_area);
  end

  // pending errors drain one per cycle, lowest source first; a new event beats the drain
  always_comb begin
    logic found;
    found = 1'b0;
    pend_nxt = pend_r;
    pcode_nxt = pcode_r;
    err_valid_nxt = 1'b0;
    err_code_nxt = err_code_r;
    for (int i = 0; i < SRC_COUNT; i++) begin
      if (pend_r[i] && !found) begin
        found = 1'b1;
        err_valid_nxt = 1'b1;
        err_code_nxt = pcode_r[i];
        pend_nxt[i] = 1'b0;
      end
      if (evt[i]) begin
        pend_nxt[i] = 1'b1;
        pcode_nxt[i] = ecode[i];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      pend_r <= '0;
      for (int i = 0; i < SRC_COUNT; i++) begin
        pcode_r[i] <= ERR_NONE;
      end
      err_valid_r <= 1'b0;
      err_code_r <= ERR_NONE;
    end else begin
      pend_r <= pend_nxt;
      pcode_r <= pcode_nxt;
      err_valid_r <= err_valid_nxt;
      err_code_r <= err_code_nxt;
    end
  end

  // outputs
  assign cur_func = func_r;
  assign cur_range = range_r[func_r];
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_ranges
      assign range_all[3*g +: 3] = range_r[g];
    end
  endgenerate
  assign config_update = update_r;
  assign secured = secured_r && !jump_s2_r;
  assign cal_busy = (cal_r == CAL_BUSY);
  assign err_valid = err_valid_r;
  assign err_code = err_code_r;
endmodule : fast_function_range_and_cal_guard

// ### hdl/meter_pkg.sv
// constants and types shared by the shortcut command and calibration guard logic
package meter_pkg;

  // measurement functions reachable by the shortcut commands
  typedef enum logic [1:0] {
    DIRECT_VOLTAGE = 2'b00,
    DIRECT_CURRENT = 2'b01,
    TWO_WIRE_OHMS = 2'b10,
    FOUR_WIRE_OHMS = 2'b11
  } func_t;

  // shortcut command kinds
  typedef enum logic [1:0] {
    OP_FUNCTION = 2'b00,
    OP_RANGE = 2'b01,
    OP_IGNORED_A = 2'b10,
    OP_IGNORED_B = 2'b11
  } op_t;

  // calibration targets named by a calibration request
  typedef enum logic [3:0] {
    CAL_DCV = 4'h0,
    CAL_DCI = 4'h1,
    CAL_RES = 4'h2,
    CAL_FOUR_WIRE_OHMS = 4'h3,
    CAL_ACV = 4'h4,
    CAL_ACI = 4'h5,
    CAL_FREQ = 4'h6,
    CAL_PERIOD = 4'h7,
    CAL_CONTINUITY = 4'h8,
    CAL_DIODE = 4'h9,
    CAL_RATIO = 4'hA
  } cal_target_t;

  typedef enum logic [0:0] {
    CAL_IDLE = 1'b0,
    CAL_BUSY = 1'b1
  } cal_state_t;

  // function codes carried in the argument of a function command
  localparam logic [3:0] FUNCTION_CODE_ONE = 4'h1;
  localparam logic [3:0] FUNCTION_CODE_TWO = 4'h2;
  localparam logic [3:0] FUNCTION_CODE_THREE = 4'h3;
  localparam logic [3:0] FUNCTION_CODE_FOUR = 4'h4;

  // range codes; code n selects the nth range of the current function
  localparam logic [2:0] RANGE_CODE_ONE = 3'h1;
  localparam logic [2:0] RANGE_CODE_TWO = 3'h2;
  localparam logic [2:0] RANGE_CODE_THREE = 3'h3;
  localparam logic [2:0] RANGE_CODE_FOUR = 3'h4;
  localparam logic [2:0] RANGE_CODE_FIVE = 3'h5;
  localparam logic [2:0] RANGE_CODE_SIX = 3'h6;
  localparam logic [2:0] RANGE_CODE_SEVEN = 3'h7;

  // highest legal range code per function
  localparam logic [2:0] MAX_RANGE_DCV = RANGE_CODE_FIVE;
  localparam logic [2:0] MAX_RANGE_DCI = RANGE_CODE_FOUR;
  localparam logic [2:0] MAX_RANGE_OHMS = RANGE_CODE_SEVEN;
  localparam logic [2:0] RANGE_100_MOHM = RANGE_CODE_SEVEN;

  // power-on state
  localparam func_t RESET_FUNC = DIRECT_VOLTAGE;
  localparam logic [2:0] RESET_RANGE_DCV = RANGE_CODE_THREE;
  localparam logic [2:0] RESET_RANGE_DCI = RANGE_CODE_THREE;
  localparam logic [2:0] RESET_RANGE_RES = RANGE_CODE_TWO;
  localparam logic [2:0] RESET_RANGE_FOUR_WIRE_OHMS = RANGE_CODE_TWO;

  // security code limits
  localparam int CODE_MAX_LEN = 12;
  localparam logic [3:0] CODE_LEN_LIMIT = 4'hC;
  localparam logic [3:0] CODE_LEN_OVER = 4'hD;

  // error numbers, signed
  localparam logic signed [10:0] ERR_NONE = 11'sh000;
  localparam logic signed [10:0] ERR_OUT_OF_RANGE = -11'sh0DE;
  localparam logic signed [10:0] ERR_CAL_JUMPER = 11'sh2BD;
  localparam logic signed [10:0] ERR_CAL_SECURED = 11'sh2BE;
  localparam logic signed [10:0] ERR_BAD_CODE = 11'sh2BF;
  localparam logic signed [10:0] ERR_CODE_LONG = 11'sh2C0;
  localparam logic signed [10:0] ERR_CAL_ABORT = 11'sh2C1;
  localparam logic signed [10:0] ERR_CAL_VALUE = 11'sh2C2;
  localparam logic signed [10:0] ERR_CAL_SIGNAL = 11'sh2C3;
  localparam logic signed [10:0] ERR_NO_CAL = 11'sh2C5;
  localparam logic signed [10:0] ERR_CKS_BASE = 11'sh2E4;
  localparam logic [3:0] CKS_AREA_LAST = 4'h8;
  localparam logic signed [10:0] ERR_ST_BASE = 11'sh258;
  localparam logic [4:0] ST_FIRST = 5'h02;
  localparam logic [4:0] ST_LAST = 5'h1A;
  localparam logic [4:0] ST_GAP_A = 5'h08;
  localparam logic [4:0] ST_GAP_B = 5'h18;

  // error sources, lower index reported first
  localparam int SRC_JUMPER = 0;
  localparam int SRC_CMD = 1;
  localparam int SRC_CODE = 2;
  localparam int SRC_CAL = 3;
  localparam int SRC_SELFTEST = 4;
  localparam int SRC_CKS = 5;
  localparam int SRC_COUNT = 6;

endpackage : meter_pkg

// ### hdl/sec_code_if.sv
// security code character stream and its verdict between guard and checker
`timescale 1ns/1ps
interface sec_code_if;
  logic char_valid;
  logic [7:0] char_data;
  logic char_last;
  logic done;
  logic too_long;
  logic bad_form;
  logic match;

  modport guard (output char_valid, output char_data, output char_last,
                 input done, input too_long, input bad_form, input match);
  modport judge (input char_valid, input char_data, input char_last,
                   output done, output too_long, output bad_form, output match);
endinterface : sec_code_if

// ### hdl/sec_code_check.sv
// security code form check and comparison against the stored code
`timescale 1ns/1ps
module sec_code_check (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // character stream and verdict
  sec_code_if.judge sc
);
  import meter_pkg::*;

  logic [7:0] stored_r [CODE_MAX_LEN];
  logic [7:0] stored_nxt [CODE_MAX_LEN];
  logic [7:0] new_r [CODE_MAX_LEN];
  logic [7:0] new_nxt [CODE_MAX_LEN];
  logic [3:0] stored_len_r, stored_len_nxt;
  logic [3:0] len_r, len_nxt;
  logic form_bad_r, form_bad_nxt;
  logic differ_r, differ_nxt;
  logic done_r, done_nxt;
  logic too_long_r, too_long_nxt;
  logic bad_form_r, bad_form_nxt;
  logic match_r, match_nxt;

  function automatic logic is_letter(input logic [7:0] c);
    is_letter = (c >= 8'h41 && c <= 8'h5A) || (c >= 8'h61 && c <= 8'h7A);
  endfunction : is_letter

  function automatic logic is_alnum(input logic [7:0] c);
    is_alnum = is_letter(c) || (c >= 8'h30 && c <= 8'h39);
  endfunction : is_alnum

  // streaming compare; length saturates at limit plus one so long codes stay flagged
  always_comb begin
    logic [3:0] len_now;
    logic bad_now;
    logic diff_now;
    len_now = len_r;
    bad_now = form_bad_r;
    diff_now = differ_r;
    stored_nxt = stored_r;
    new_nxt = new_r;
    stored_len_nxt = stored_len_r;
    len_nxt = len_r;
    form_bad_nxt = form_bad_r;
    differ_nxt = differ_r;
    done_nxt = 1'b0;
    too_long_nxt = too_long_r;
    bad_form_nxt = bad_form_r;
    match_nxt = match_r;
    if (sc.char_valid) begin
      if (len_r < CODE_LEN_LIMIT) begin
        new_nxt[len_r] = sc.char_data;
        diff_now = differ_r || (len_r >= stored_len_r) || (stored_r[len_r] != sc.char_data);
        bad_now = form_bad_r || !is_alnum(sc.char_data) || ((len_r == 4'h0) && !is_letter(sc.char_data));
      end
      if (len_r != CODE_LEN_OVER) begin
        len_now = len_r + 4'h1;
      end
      len_nxt = len_now;
      form_bad_nxt = bad_now;
      differ_nxt = diff_now;
      if (sc.char_last) begin
        done_nxt = 1'b1;
        too_long_nxt = (len_now > CODE_LEN_LIMIT);
        bad_form_nxt = bad_now;
        // an empty store takes the first well formed code
        match_nxt = (stored_len_r == 4'h0) || (!diff_now && len_now == stored_len_r);
        if (stored_len_r == 4'h0 && !bad_now && len_now <= CODE_LEN_LIMIT) begin
          stored_nxt = new_nxt;
          stored_len_nxt = len_now;
        end
        len_nxt = 4'h0;
        form_bad_nxt = 1'b0;
        differ_nxt = 1'b0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      for (int i = 0; i < CODE_MAX_LEN; i++) begin
        stored_r[i] <= 8'h00;
        new_r[i] <= 8'h00;
      end
      stored_len_r <= 4'h0;
      len_r <= 4'h0;
      form_bad_r <= 1'b0;
      differ_r <= 1'b0;
      done_r <= 1'b0;
      too_long_r <= 1'b0;
      bad_form_r <= 1'b0;
      match_r <= 1'b0;
    end else begin
      stored_r <= stored_nxt;
      new_r <= new_nxt;
      stored_len_r <= stored_len_nxt;
      len_r <= len_nxt;
      form_bad_r <= form_bad_nxt;
      differ_r <= differ_nxt;
      done_r <= done_nxt;
      too_long_r <= too_long_nxt;
      bad_form_r <= bad_form_nxt;
      match_r <= match_nxt;
    end
  end

  assign sc.done = done_r;
  assign sc.too_long = too_long_r;
  assign sc.bad_form = bad_form_r;
  assign sc.match = match_r;
endmodule : sec_code_check

// ### tb/guard_props.sv
// assertions on the guard block ports
`timescale 1ns/1ps
module guard_props (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // requests
  input wire logic cmd_valid,
  input wire meter_pkg::op_t cmd_op,
  input wire logic [3:0] cmd_arg,
  input wire logic cal_req,
  input wire meter_pkg::cal_target_t cal_target,
  input wire logic dev_clear,
  input wire logic st_fail_valid,
  input wire logic [4:0] st_fail_num,
  input wire logic cks_fail_valid,
  input wire logic [3:0] cks_area,
  // results
  input wire meter_pkg::func_t cur_func,
  input wire logic [2:0] cur_range,
  input wire logic [11:0] range_all,
  input wire logic config_update,
  input wire logic secured,
  input wire logic cal_busy,
  input wire logic err_valid,
  input wire logic signed [10:0] err_code
);
  import meter_pkg::*;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);
  logic fn_cmd;
  logic rg_cmd;
  logic rg_ok;
  logic [2:0] top;
  // highest range code the selected function takes
  always_comb begin
    case (cur_func)
      DIRECT_VOLTAGE: top = MAX_RANGE_DCV;
      DIRECT_CURRENT: top = MAX_RANGE_DCI;
      default: top = MAX_RANGE_OHMS;
    endcase
  end
  // decoded strobes
  assign fn_cmd = cmd_valid && cmd_op == OP_FUNCTION;
  assign rg_cmd = cmd_valid && cmd_op == OP_RANGE;
  assign rg_ok = cmd_arg != 4'h0 && cmd_arg <= {1'b0, top};
  a_func_select: assert property (
    fn_cmd && cmd_arg inside {[4'h1:4'h4]} |=> config_update && cur_func == 2'($past(cmd_arg) - 4'h1))
    else $error("func not set");
  a_func_refuse: assert property (
    fn_cmd && !(cmd_arg inside {[4'h1:4'h4]}) |=> !config_update && $stable(cur_func))
    else $error("bad func taken");
  a_range_set: assert property (
    rg_cmd && rg_ok |=> config_update && cur_range == $past(cmd_arg[2:0]))
    else $error("range not set");
  a_range_bad: assert property (
    rg_cmd && !rg_ok |=> $stable(range_all) ##1 (err_valid && err_code == ERR_OUT_OF_RANGE))
    else $error("bad range taken");
  a_range_only: assert property (
    rg_cmd |=> ((range_all ^ $past(range_all)) & ~(12'h007 << (3 * $past(cur_func)))) == 12'h000)
    else $error("other range moved");
  a_range_recall: assert property (
    cur_range == range_all[3 * cur_func +: 3])
    else $error("range not recalled");
  a_cal_secured: assert property (
    cal_req && !cal_busy && secured |=> !cal_busy ##1 (err_valid && err_code == ERR_CAL_SECURED))
    else $error("secured cal ran");
  a_cal_nocal: assert property (
    cal_req && !cal_busy && !secured && cal_target inside {CAL_ACI, CAL_PERIOD, CAL_CONTINUITY, CAL_DIODE, CAL_RATIO}
    |=> !cal_busy ##1 (err_valid && err_code == ERR_NO_CAL))
    else $error("refused cal ran");
  a_cal_abort: assert property (
    cal_busy && dev_clear |=> !cal_busy ##1 (err_valid && err_code == ERR_CAL_ABORT))
    else $error("no abort");
  a_selftest_code: assert property (
    st_fail_valid && st_fail_num inside {[ST_FIRST:ST_LAST]} && st_fail_num != ST_GAP_A && st_fail_num != ST_GAP_B
    |-> ##2 (err_valid && err_code == ERR_ST_BASE + 11'($past(st_fail_num, 2))))
    else $error("self-test code");
  a_cks_code: assert property (
    cks_fail_valid && cks_area <= CKS_AREA_LAST |-> ##2 (err_valid && err_code == ERR_CKS_BASE + 11'($past(cks_area, 2))))
    else $error("checksum code");
endmodule : guard_props

bind fast_function_range_and_cal_guard guard_props u_guard_props (.*);

// ### tb/host_model.sv
// host model issuing shortcut commands and codes
`timescale 1ns/1ps
module host_model (
  // clock
  input wire logic clock,
  // shortcut commands
  output logic cmd_valid = 1'b0,
  output meter_pkg::op_t cmd_op = meter_pkg::OP_IGNORED_A,
  output logic [3:0] cmd_arg = 4'h0,
  // security code stream
  output logic code_valid = 1'b0,
  output logic [7:0] code_char = 8'h00,
  output logic code_last = 1'b0,
  output logic code_unsecure = 1'b0
);
  import meter_pkg::*;
  // one strobe cycle; argument inverted on release
  task automatic cmd(input op_t op, input logic [3:0] arg);
    @(negedge clock);
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_arg = arg;
    @(negedge clock);
    cmd_valid = 1'b0;
    cmd_arg = ~arg;
  endtask : cmd
  // characters back to back
  task automatic code(input string s, input logic unsec);
    for (int i = 0; i < s.len(); i++) begin
      @(negedge clock);
      code_valid = 1'b1;
      code_char = s[i];
      code_last = i == s.len() - 1;
      code_unsecure = unsec;
    end
    @(negedge clock);
    code_valid = 1'b0;
    code_char = ~code_char;
    code_last = 1'b0;
  endtask : code
endmodule : host_model

// ### tb/fast_function_range_and_cal_guard_bench.sv
// self-checking bench for the guard block
`timescale 1ns/1ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin err_total++; \
  $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module fast_function_range_and_cal_guard_bench;
  import meter_pkg::*;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic cmd_valid, code_valid, code_last, code_unsecure;
  op_t cmd_op;
  logic [3:0] cmd_arg;
  logic [7:0] code_char;
  logic cal_req = 1'b0, cal_value_bad = 1'b0, cal_signal_bad = 1'b0, cal_done = 1'b0, dev_clear = 1'b0;
  cal_target_t cal_target = CAL_DCV;
  logic st_fail_valid = 1'b0, cks_fail_valid = 1'b0, sec_jumper_off = 1'b0;
  logic [4:0] st_fail_num = 5'h00;
  logic [3:0] cks_area = 4'h0;
  func_t cur_func;
  logic [2:0] cur_range;
  logic [11:0] range_all;
  logic config_update, secured, cal_busy, err_valid;
  logic signed [10:0] err_code;
  int err_total = 0;
  int samples_checked = 0;

  always #5 clock = ~clock;

  fast_function_range_and_cal_guard u_fast_function_range_and_cal_guard (.*);
  host_model u_host_model (.*);

  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : summarize

  task automatic do_reset();
    nrst = 1'b0;
    repeat (16) @(negedge clock);
    nrst = 1'b1;
  endtask : do_reset

  // error pulse n falling edges on
  task automatic err_at(input int n, input logic signed [10:0] e);
    repeat (n) @(negedge clock);
    `CHK("err_valid", 1'b1, err_valid)
    `CHK("err_code", e, err_code)
  endtask : err_at

  task automatic pulse_cal(input cal_target_t t);
    cal_req = 1'b1;
    cal_target = t;
    @(negedge clock);
    cal_req = 1'b0;
  endtask : pulse_cal

  // every function at its top range, then one past it
  task automatic t_func_range();
    logic [2:0] top [4] = '{3'h5, 3'h4, 3'h7, 3'h7};
    `CHK("range_all", {RESET_RANGE_FOUR_WIRE_OHMS, RESET_RANGE_RES, RESET_RANGE_DCI, RESET_RANGE_DCV}, range_all)
    for (int f = 0; f < 4; f++) begin
      u_host_model.cmd(OP_FUNCTION, 4'(f + 1));
      `CHK("cur_func", f[1:0], cur_func)
      `CHK("config_update", 1'b1, config_update)
      u_host_model.cmd(OP_RANGE, {1'b0, top[f]});
      `CHK("cur_range", top[f], cur_range)
      u_host_model.cmd(OP_RANGE, {1'b0, top[f]} + 4'h1);
      `CHK("cur_range", top[f], cur_range)
      err_at(1, ERR_OUT_OF_RANGE);
    end
    `CHK("range_all", 12'hFE5, range_all)
    u_host_model.cmd(OP_FUNCTION, 4'h1);
    `CHK("cur_range", 3'h5, cur_range)
    u_host_model.cmd(OP_FUNCTION, 4'h5);
    `CHK("config_update", 1'b0, config_update)
    `CHK("cur_func", DIRECT_VOLTAGE, cur_func)
    err_at(1, ERR_OUT_OF_RANGE);
  endtask : t_func_range

  // store a code, refusals, secure again
  task automatic t_codes();
    `CHK("secured", 1'b1, secured)
    u_host_model.code("K1234567890Z", 1'b1);
    repeat (2) @(negedge clock);
    `CHK("secured", 1'b0, secured)
    u_host_model.code("K1234567890Y", 1'b0);
    err_at(2, ERR_BAD_CODE);
    u_host_model.code("1AB", 1'b0);
    err_at(2, ERR_BAD_CODE);
    u_host_model.code("A-B", 1'b0);
    err_at(2, ERR_BAD_CODE);
    u_host_model.code("K1234567890Z1", 1'b0);
    err_at(2, ERR_CODE_LONG);
    `CHK("secured", 1'b0, secured)
    u_host_model.code("K1234567890Z", 1'b0);
    repeat (2) @(negedge clock);
    `CHK("secured", 1'b1, secured)
  endtask : t_codes

  // secured refusal, run endings, refused targets
  task automatic t_cal();
    logic [3:0] ends [4] = '{4'h8, 4'h4, 4'h2, 4'h1};
    logic signed [10:0] ecode [3] = '{ERR_CAL_ABORT, ERR_CAL_VALUE, ERR_CAL_SIGNAL};
    cal_target_t bad [5] = '{CAL_ACI, CAL_PERIOD, CAL_CONTINUITY, CAL_DIODE, CAL_RATIO};
    pulse_cal(CAL_DCV);
    `CHK("cal_busy", 1'b0, cal_busy)
    err_at(1, ERR_CAL_SECURED);
    u_host_model.code("K1234567890Z", 1'b1);
    repeat (2) @(negedge clock);
    for (int k = 0; k < 4; k++) begin
      pulse_cal(CAL_DCV);
      `CHK("cal_busy", 1'b1, cal_busy)
      {dev_clear, cal_value_bad, cal_signal_bad, cal_done} = ends[k];
      @(negedge clock);
      {dev_clear, cal_value_bad, cal_signal_bad, cal_done} = 4'h0;
      `CHK("cal_busy", 1'b0, cal_busy)
      if (k < 3) begin
        err_at(1, ecode[k]);
      end else begin
        @(negedge clock);
        `CHK("err_valid", 1'b0, err_valid)
      end
    end
    foreach (bad[i]) begin
      pulse_cal(bad[i]);
      `CHK("cal_busy", 1'b0, cal_busy)
      err_at(1, ERR_NO_CAL);
    end
    // two-wire ohms still holds its top range
    u_host_model.cmd(OP_FUNCTION, 4'h3);
    pulse_cal(CAL_RES);
    err_at(1, ERR_NO_CAL);
  endtask : t_cal

  // all self-test numbers and checksum areas
  task automatic t_reports();
    for (int n = 2; n <= 26; n++) begin
      st_fail_valid = 1'b1;
      st_fail_num = 5'(n);
      @(negedge clock);
      st_fail_valid = 1'b0;
      if (n == 8 || n == 24) begin
        @(negedge clock);
        `CHK("err_valid", 1'b0, err_valid)
      end else begin
        err_at(1, ERR_ST_BASE + 11'(n));
      end
    end
    for (int a = 0; a <= 8; a++) begin
      cks_fail_valid = 1'b1;
      cks_area = 4'(a);
      @(negedge clock);
      cks_fail_valid = 1'b0;
      err_at(1, ERR_CKS_BASE + 11'(a));
    end
  endtask : t_reports

  task automatic t_jumper();
    sec_jumper_off = 1'b1;
    do_reset();
    err_at(4, ERR_CAL_JUMPER);
    `CHK("secured", 1'b0, secured)
  endtask : t_jumper

  // watchdog, far beyond the scenarios
  initial begin
    #100us;
    err_total++;
    summarize();
  end

  initial begin
    do_reset();
    t_func_range();
    t_codes();
    t_cal();
    t_reports();
    t_jumper();
    summarize();
  end
endmodule : fast_function_range_and_cal_guard_bench
